//--- hw/rsmi_pkg.sv
package rsmi_pkg;
  // Register addresses: page select is bit 6 of the main status register
  localparam logic [4:0] ADDR_MAIN_STATUS = 5'h00;
  localparam logic [4:0] ADDR_PERIODIC_FLAG = 5'h03;
  localparam logic [4:0] ADDR_TIME_SAVE = 5'h04;
  localparam logic [4:0] ADDR_RT_MODE = 5'h01;
  localparam logic [4:0] ADDR_OUT_MODE = 5'h02;
  localparam logic [4:0] ADDR_PERIODIC_EN = 5'h03;
  localparam logic [4:0] ADDR_ALARM_PF_EN = 5'h04;
  localparam logic [4:0] ADDR_RAM_TEST = 5'h1F;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h1C;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h1D;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h1E;
  // Bit positions
  localparam int BIT_REG_SELECT = 6;
  localparam int BIT_TEST_MODE = 7;
  localparam int BIT_OSC_FAIL = 6;
  localparam int BIT_CLOCK_RUN = 3;
  localparam int BIT_IRQ_ON_BACKUP = 4;
  localparam int BIT_PF_ENABLE = 7;
  localparam int BIT_ALARM_ENABLE = 6;
  localparam int BIT_MFO_CRYSTAL = 7;
  localparam int BIT_OSC_FAIL_INHIBIT = 0;
  // Event bits in the interrupt status register
  localparam int EV_STANDBY_ENTER = 0;
  localparam int EV_STANDBY_EXIT = 1;
  localparam int EV_OSC_FAIL = 2;
  localparam int EV_CLOCK_BLOCKED = 3;
  localparam int EV_COUNT = 4;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] PERIODIC_EN_STANDBY_MASK = 8'h3F;
  localparam logic [7:0] ALARM_PF_STANDBY_MASK = 8'hC0;
  localparam int SYNC_STAGES = 3;
endpackage : rsmi_pkg

//--- hw/rsmi_control.sv
// What this block does
// - Periodic flag bit 7 writes enter/leave test
// - Zero write to 1Fh in test clears
// - Clock start sets only while oscillator fail is clear
// - Periodic flag bit 6 reads oscillator fail
// - Bit 6 write picks supply mode, guarded
// - Power fail enable arms power fail input
// - Backup bit keeps power fail enable in standby
// - Standby in battery mode without backup bit clears enables
module rsmi_control (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic osc_running_i,
  input wire logic batt_above_main_i,
  input wire logic power_fail_input_i,
  output logic test_mode_o,
  output logic clock_run_o,
  output logic single_supply_o,
  output logic power_fail_armed_o,
  output logic power_fail_irq_o,
  output logic standby_o,
  output logic multi_function_output_o,
  output logic irq_o
);

  // Three-stage synchronisers for pin inputs
  // Raw shift registers, one per pin
  logic [rsmi_pkg::SYNC_STAGES-1:0] osc_sync_r;
  logic [rsmi_pkg::SYNC_STAGES-1:0] sby_sync_r;
  logic [rsmi_pkg::SYNC_STAGES-1:0] pf_sync_r;

  // Filtered levels after stages agree
  logic osc_run_r;
  logic standby_r;
  logic pf_pin_r;

  // Register state
  // Page select lives here
  logic [7:0] main_status_r;

  // Periodic flag state
  logic test_mode_r;
  logic single_supply_r;

  // Page one control bytes
  logic [7:0] rt_mode_r;
  logic [7:0] out_mode_r;

  // Page zero spare storage
  logic [7:0] time_save_r;

  // Enables cleared on standby entry
  logic [7:0] periodic_en_r;
  logic [7:0] alarm_pf_en_r;

  // Test conditions, inhibit in bit 0
  logic [7:0] ram_test_r;

  // Event status and its mask
  logic [rsmi_pkg::EV_COUNT-1:0] irq_status_r;
  logic [rsmi_pkg::EV_COUNT-1:0] irq_enable_r;

  // Registered outputs
  logic [7:0] rdata_r;
  logic irq_r;
  logic pf_irq_r;
  logic mfo_r;

  // Combinational decode
  // Page select decoded
  logic page1;
  // Oscillator fail as software sees it
  logic osc_fail;
  // One-cycle standby entry pulse
  logic standby_rise;
  // One-cycle standby exit pulse
  logic standby_fall;
  // Periodic flag write, page zero
  logic wr_flag;
  // Real time mode write, page one
  logic wr_mode;
  // Periodic enable write
  logic wr_pen;
  // Alarm and power fail enable write
  logic wr_apen;
  // Refused clock start attempt
  logic clock_start_blocked;
  // Event pulses into status
  logic [rsmi_pkg::EV_COUNT-1:0] events;

  // Page and per-register write strobes
  assign page1 = main_status_r[rsmi_pkg::BIT_REG_SELECT];
  assign wr_flag = wr_i && !page1 && addr_i == rsmi_pkg::ADDR_PERIODIC_FLAG;
  assign wr_mode = wr_i && page1 && addr_i == rsmi_pkg::ADDR_RT_MODE;
  assign wr_pen = wr_i && page1 && addr_i == rsmi_pkg::ADDR_PERIODIC_EN;
  assign wr_apen = wr_i && page1 && addr_i == rsmi_pkg::ADDR_ALARM_PF_EN;

  // Oscillator fail unless running, or unless test inhibit is set
  assign osc_fail = !osc_run_r && !ram_test_r[rsmi_pkg::BIT_OSC_FAIL_INHIBIT];

  // Standby edges from the synchronised supply comparator
  assign standby_rise = (sby_sync_r[2] == sby_sync_r[1]) && sby_sync_r[1] && !standby_r;
  assign standby_fall = (sby_sync_r[2] == sby_sync_r[1]) && !sby_sync_r[1] && standby_r;

  // A refused start is logged as an event
  assign clock_start_blocked = wr_mode && wdata_i[rsmi_pkg::BIT_CLOCK_RUN] && osc_fail;

  // Events feeding the sticky status
  always_comb begin
    events = '0;
    // Standby entry and exit
    events[rsmi_pkg::EV_STANDBY_ENTER] = standby_rise;
    events[rsmi_pkg::EV_STANDBY_EXIT] = standby_fall;
    // Failure is a level and re-sets
    events[rsmi_pkg::EV_OSC_FAIL] = osc_fail;
    // Clock start refused
    events[rsmi_pkg::EV_CLOCK_BLOCKED] = clock_start_blocked;
  end

  // Input synchronisers; second and third stages must agree
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      // Flush all stages
      osc_sync_r <= '0;
      sby_sync_r <= '0;
      pf_sync_r <= '0;
    end else begin
      // Shift each pin one stage per clock
      osc_sync_r <= {osc_sync_r[1:0], osc_running_i};
      sby_sync_r <= {sby_sync_r[1:0], batt_above_main_i};
      pf_sync_r <= {pf_sync_r[1:0], power_fail_input_i};
    end
  end

  // Filtered levels
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      // Oscillator assumed stopped
      osc_run_r <= 1'b0;
      standby_r <= 1'b0;
      pf_pin_r <= 1'b0;
    end else begin
      // Hold the last level while stages disagree
      if (osc_sync_r[2] == osc_sync_r[1]) osc_run_r <= osc_sync_r[1];
      if (sby_sync_r[2] == sby_sync_r[1]) standby_r <= sby_sync_r[1];
      if (pf_sync_r[2] == pf_sync_r[1]) pf_pin_r <= pf_sync_r[1];
    end
  end

  // Main status page select and spare bits
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      // Page zero after reset
      main_status_r <= rsmi_pkg::RESET_BYTE;
    end else if (wr_i && addr_i == rsmi_pkg::ADDR_MAIN_STATUS) begin
      main_status_r <= wdata_i;
    end
  end

  // Test mode and supply mode from the periodic flag register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      test_mode_r <= 1'b0;
      // Single supply until software chooses
      single_supply_r <= 1'b1;
    end else if (wr_flag) begin
      test_mode_r <= wdata_i[rsmi_pkg::BIT_TEST_MODE];
      if (wdata_i[rsmi_pkg::BIT_OSC_FAIL]) begin
        single_supply_r <= 1'b1;
      end else if (!osc_fail) begin
        // Battery mode only while oscillator fail is clear
        single_supply_r <= 1'b0;
      end
    end
  end

  // Test register; a zero write in test mode clears every test condition
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ram_test_r <= rsmi_pkg::RESET_BYTE;
    end else if (wr_i && !page1 && addr_i == rsmi_pkg::ADDR_RAM_TEST) begin
      // Writes outside test mode are dropped
      if (test_mode_r) ram_test_r <= wdata_i;
    end
  end

  // Real time mode; clock start accepted only while oscillator fail is clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rt_mode_r <= rsmi_pkg::RESET_BYTE;
    end else if (wr_mode) begin
      // Keep other bits as written
      rt_mode_r <= wdata_i;
      rt_mode_r[rsmi_pkg::BIT_CLOCK_RUN] <= wdata_i[rsmi_pkg::BIT_CLOCK_RUN] && !osc_fail;
    end else if (osc_fail && !test_mode_r) begin
      // Oscillator fail stops the clock outside test mode
      rt_mode_r[rsmi_pkg::BIT_CLOCK_RUN] <= 1'b0;
    end
  end

  // Output mode and time save control are plain storage
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_mode_r <= rsmi_pkg::RESET_BYTE;
      time_save_r <= rsmi_pkg::RESET_BYTE;
    end else if (wr_i && addr_i == rsmi_pkg::ADDR_OUT_MODE && page1) begin
      // Output mode is page one, time save page zero
      out_mode_r <= wdata_i;
    end else if (wr_i && addr_i == rsmi_pkg::ADDR_TIME_SAVE && !page1) begin
      time_save_r <= wdata_i;
    end
  end

  // Periodic enables; cleared on standby entry in battery mode without backup bit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      periodic_en_r <= rsmi_pkg::RESET_BYTE;
    end else if (standby_rise && !single_supply_r && !rt_mode_r[rsmi_pkg::BIT_IRQ_ON_BACKUP]) begin
      periodic_en_r <= periodic_en_r & ~rsmi_pkg::PERIODIC_EN_STANDBY_MASK;
    end else if (wr_pen && !standby_r) begin
      // Host writes are locked out in standby
      periodic_en_r <= wdata_i;
    end
  end

  // Alarm and power fail enables; backup bit holds them through standby
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      alarm_pf_en_r <= rsmi_pkg::RESET_BYTE;
    end else if (standby_rise && !single_supply_r && !rt_mode_r[rsmi_pkg::BIT_IRQ_ON_BACKUP]) begin
      alarm_pf_en_r <= alarm_pf_en_r & ~rsmi_pkg::ALARM_PF_STANDBY_MASK;
    end else if (wr_apen && !standby_r) begin
      // Host writes are locked out in standby
      alarm_pf_en_r <= wdata_i;
    end
  end

  // Power fail interrupt and output pin select
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pf_irq_r <= 1'b0;
      mfo_r <= 1'b0;
    end else begin
      // Standby counts as a power fail
      pf_irq_r <= alarm_pf_en_r[rsmi_pkg::BIT_PF_ENABLE] && (pf_pin_r || standby_r);
      // Pin select: oscillator or active-low interrupt
      mfo_r <= out_mode_r[rsmi_pkg::BIT_MFO_CRYSTAL] ? osc_run_r :
               !(alarm_pf_en_r[rsmi_pkg::BIT_PF_ENABLE] && (pf_pin_r || standby_r));
    end
  end

  // Sticky event status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_status_r <= '0;
      irq_enable_r <= '0;
    end else begin
      if (wr_i && addr_i == rsmi_pkg::ADDR_IRQ_CLEAR) begin
        // Clear write takes its bits away; new events still land
        irq_status_r <= (irq_status_r & ~wdata_i[rsmi_pkg::EV_COUNT-1:0]) | events;
      end else begin
        irq_status_r <= irq_status_r | events;
      end
      // Enable mask is plain storage
      if (wr_i && addr_i == rsmi_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable_r <= wdata_i[rsmi_pkg::EV_COUNT-1:0];
      end
    end
  end

  // Interrupt output
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) irq_r <= 1'b0;
    else irq_r <= |(irq_status_r & irq_enable_r);
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= rsmi_pkg::RESET_BYTE;
    end else if (rd_i) begin
      rdata_r <= rsmi_pkg::RESET_BYTE;
      case (addr_i)
        // Main status on both pages
        rsmi_pkg::ADDR_MAIN_STATUS: rdata_r <= main_status_r;
        // Page one shares 03 and 04 with page zero
        rsmi_pkg::ADDR_PERIODIC_FLAG: begin
          if (page1) rdata_r <= periodic_en_r;
          else rdata_r <= {test_mode_r, osc_fail, 6'h00};
        end
        rsmi_pkg::ADDR_TIME_SAVE: rdata_r <= page1 ? alarm_pf_en_r : time_save_r;
        // Page one only
        rsmi_pkg::ADDR_RT_MODE: rdata_r <= page1 ? rt_mode_r : rsmi_pkg::RESET_BYTE;
        rsmi_pkg::ADDR_OUT_MODE: rdata_r <= page1 ? out_mode_r : rsmi_pkg::RESET_BYTE;
        // Page zero only
        rsmi_pkg::ADDR_RAM_TEST: rdata_r <= page1 ? rsmi_pkg::RESET_BYTE : ram_test_r;
        // Status and mask are page-independent
        rsmi_pkg::ADDR_IRQ_STATUS: rdata_r <= {4'h0, irq_status_r};
        rsmi_pkg::ADDR_IRQ_ENABLE: rdata_r <= {4'h0, irq_enable_r};
        // Unmapped reads give zero
        default: rdata_r <= rsmi_pkg::RESET_BYTE;
      endcase
    end else begin
      // Idle bus reads as zero
      rdata_r <= rsmi_pkg::RESET_BYTE;
    end
  end

  // Outputs straight from registers
  // Bus side
  assign rdata_o = rdata_r;

  // Mode bits
  assign test_mode_o = test_mode_r;
  // Clock start bit as accepted
  assign clock_run_o = rt_mode_r[rsmi_pkg::BIT_CLOCK_RUN];
  // Supply mode, one is single supply
  assign single_supply_o = single_supply_r;

  // Power fail and standby
  assign power_fail_armed_o = alarm_pf_en_r[rsmi_pkg::BIT_PF_ENABLE];
  assign power_fail_irq_o = pf_irq_r;
  // Filtered supply comparator
  assign standby_o = standby_r;

  // Pin and interrupt
  assign multi_function_output_o = mfo_r;
  // Level interrupt, one cycle behind status
  assign irq_o = irq_r;

endmodule // rsmi_control

//--- sim/rsmi_control_monitor.sv
module rsmi_control_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic batt_above_main_i,
  input wire logic test_mode_o,
  input wire logic clock_run_o,
  input wire logic single_supply_o,
  input wire logic power_fail_armed_o,
  input wire logic power_fail_irq_o,
  input wire logic standby_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Flag register write, shared by test and supply checks
  sequence s_flag_wr;
    $past(wr_i && addr_i == 5'h03);
  endsequence
  // Output changes must trace back to the write or supply input that caused them
  property p_test_on;
    $rose(test_mode_o) |-> s_flag_wr and $past(wdata_i[7]);
  endproperty
  property p_test_off;
    $fell(test_mode_o) |-> s_flag_wr and $past(!wdata_i[7]);
  endproperty
  property p_clk_start;
    $rose(clock_run_o) |-> $past(wr_i && addr_i == 5'h01 && wdata_i[3]);
  endproperty
  property p_batt_mode;
    $fell(single_supply_o) |-> s_flag_wr and $past(!wdata_i[6]);
  endproperty
  property p_arm;
    $rose(power_fail_armed_o) |-> $past(wr_i && addr_i == 5'h04 && wdata_i[7]);
  endproperty
  property p_disarm;
    $fell(power_fail_armed_o) |-> $past(wr_i) || standby_o;
  endproperty
  property p_pf_irq;
    power_fail_irq_o |-> $past(power_fail_armed_o);
  endproperty
  property p_standby;
    $rose(standby_o) |-> $past(batt_above_main_i);
  endproperty
  a_test_on: assert property (p_test_on) else $error("test mode set without write");
  a_test_off: assert property (p_test_off) else $error("test mode left without write");
  a_clk_start: assert property (p_clk_start) else $error("clock start set unasked");
  a_batt_mode: assert property (p_batt_mode) else $error("supply mode changed unasked");
  a_arm: assert property (p_arm) else $error("power fail armed unasked");
  a_disarm: assert property (p_disarm) else $error("power fail disarmed unasked");
  a_pf_irq: assert property (p_pf_irq) else $error("power fail irq while unarmed");
  a_standby: assert property (p_standby) else $error("standby without supply input");
endmodule // rsmi_control_monitor

//--- sim/rsmi_host_model.sv
module rsmi_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial begin
    addr_o = 5'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One-cycle write; its effect has landed by the falling edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(negedge clk_i);
  endtask
  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  // Page select lives in bit 6 of the main status register
  task automatic pg(input logic p);
    wr(5'h00, {1'b0, p, 6'h00});
  endtask
endmodule // rsmi_host_model

//--- sim/rsmi_control_tb.sv
module rsmi_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic osc = 1'b0;
  logic batt = 1'b0;
  logic pf = 1'b0;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, tm, run, ss, arm, pfi, sb, multi_function_output, irq;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
  rsmi_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  rsmi_control dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .osc_running_i(osc), .batt_above_main_i(batt),
    .power_fail_input_i(pf), .test_mode_o(tm), .clock_run_o(run), .single_supply_o(ss),
    .power_fail_armed_o(arm), .power_fail_irq_o(pfi), .standby_o(sb),
    .multi_function_output_o(multi_function_output), .irq_o(irq));
  // Clock, 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bring-up sequence of a host, then standby behaviour
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    w(6);
    `CHK("ss_reset", 1'b1, ss)
    host_u.pg(1'b0);
    host_u.rd(5'h03, d);
    `CHK("osc_fail", 1'b1, d[6])
    host_u.wr(5'h03, 8'h00);
    `CHK("ss_guard", 1'b1, ss)
    host_u.wr(5'h03, 8'h80);
    `CHK("test_on", 1'b1, tm)
    host_u.wr(5'h1F, 8'h01);
    host_u.rd(5'h03, d);
    `CHK("inhibit", 1'b0, d[6])
    host_u.wr(5'h1F, 8'h00);
    host_u.rd(5'h03, d);
    `CHK("inhibit_clr", 1'b1, d[6])
    host_u.wr(5'h03, 8'h00);
    `CHK("test_off", 1'b0, tm)
    host_u.pg(1'b1);
    host_u.wr(5'h01, 8'h08);
    `CHK("clk_blocked", 1'b0, run)
    `CHK("masked", 1'b0, irq)
    @(posedge clk_i);
    osc <= 1'b1;
    d = 8'hFF;
    // Retry clock start until the oscillator flag clears
    for (int i = 0; i < 20 && d[6] !== 1'b0; i++) begin
      host_u.pg(1'b0);
      host_u.rd(5'h03, d);
      host_u.pg(1'b1);
      host_u.wr(5'h01, 8'h08);
    end
    `CHK("osc_ok", 1'b0, d[6])
    `CHK("clk_run", 1'b1, run)
    host_u.pg(1'b0);
    host_u.wr(5'h03, 8'h00);
    `CHK("batt_mode", 1'b0, ss)
    host_u.pg(1'b1);
    host_u.wr(5'h04, 8'h80);
    host_u.wr(5'h03, 8'h3F);
    `CHK("armed", 1'b1, arm)
    @(posedge clk_i);
    pf <= 1'b1;
    w(8);
    `CHK("pf_irq", 1'b1, pfi)
    `CHK("mfo_pf", 1'b0, multi_function_output)
    @(posedge clk_i);
    batt <= 1'b1;
    pf <= 1'b0;
    w(8);
    `CHK("standby", 1'b1, sb)
    `CHK("disarmed", 1'b0, arm)
    host_u.rd(5'h03, d);
    `CHK("periodic_clr", 8'h00, d)
    host_u.rd(5'h1C, d);
    `CHK("ev_standby", 1'b1, d[0])
    host_u.wr(5'h1D, 8'h01);
    w(2);
    `CHK("irq_on", 1'b1, irq)
    host_u.wr(5'h1E, 8'h01);
    w(2);
    `CHK("irq_off", 1'b0, irq)
    @(posedge clk_i);
    batt <= 1'b0;
    w(8);
    host_u.wr(5'h04, 8'h80);
    host_u.wr(5'h01, 8'h18);
    @(posedge clk_i);
    batt <= 1'b1;
    w(8);
    `CHK("pf_kept", 1'b1, arm)
    host_u.rd(5'h05, d);
    `CHK("unmapped", 8'h00, d)
    end_sim();
  end
endmodule // rsmi_control_tb
bind rsmi_control rsmi_control_monitor mon_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .batt_above_main_i(batt_above_main_i),
  .test_mode_o(test_mode_o), .clock_run_o(clock_run_o), .single_supply_o(single_supply_o),
  .power_fail_armed_o(power_fail_armed_o), .power_fail_irq_o(power_fail_irq_o),
  .standby_o(standby_o));
